// >>> core/qscq_pkg.sv
// Purpose: Shared constants and types for the queued serial command queue
// Assumes: 40 MHz system clock, 16-entry command, transmit and receive memories
// Notes: Delay figures are in system clocks already, so counts equal the figures
package qscq_pkg;
    localparam int ENTRIES = 16;
    localparam int PTR_W = 4;
    localparam int WORD_W = 16;
    localparam int CMD_W = 8;
    localparam int CNT_W = 5;
    localparam int TMR_W = 14;
    // Command byte layout
    localparam int CMD_KEEP_POS = 7;
    localparam int CMD_WIDTH_POS = 6;
    localparam int CMD_POST_POS = 5;
    localparam int CMD_CLKDLY_POS = 4;
    localparam int CMD_SEL_MSB = 3;
    // Transfer widths and delays, in bits and system clocks
    localparam logic [CNT_W-1:0] DEFAULT_BITS = 5'h08;
    localparam logic [CNT_W-1:0] FULL_BITS = 5'h10;
    localparam logic [TMR_W-1:0] STD_POST_CLOCKS = 14'h0011;
    localparam int POST_UNIT_SHIFT = 5;
    localparam int POST_ZERO_CLOCKS = 8192;
    // Reset values
    localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
    localparam logic [3:0] SEL_RELEASED = 4'hf;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    typedef struct packed {
        logic keep_select_bit;
        logic width_select_bit;
        logic post_delay_select;
        logic clock_delay_select;
        logic [3:0] peripheral_select;
    } qscq_cmd_type;

    typedef struct packed {
        logic serial_enable;
        logic master_select;
        logic [3:0] bits_per_transfer;
        logic [7:0] sck_half_period;
        logic [6:0] clock_delay_length;
        logic [7:0] post_delay_length;
        logic [PTR_W-1:0] queue_start_pointer;
        logic [PTR_W-1:0] queue_end_pointer;
    } qscq_cfg_type;

    typedef struct packed {
        logic finished_flag;
        logic mode_fault_flag;
        logic busy;
        logic [PTR_W-1:0] completed_pointer;
    } qscq_status_type;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LEAD = 5'b00010,
        ST_SHIFT = 5'b00100,
        ST_POST = 5'b01000,
        ST_SLAVE = 5'b10000
    } qscq_state_type;
endpackage

// >>> core/qscq_core.sv
// Purpose: Command queue engine of a queued synchronous serial port, master or slave
// Assumes: Host fills memories through write ports; external clock drives slave frames
// Notes: Master clock idles low, data changes on falling and is sampled on rising edge
//
// Behaviour
// - Sixteen byte-wide command entries, written only by the host.
// - Each command splits into chip-select field and control field.
// - Bit7 keep, bit6 width, bit5 post delay, bit4 clock delay, bits3-0 selects.
// - Queue runs from start pointer through end pointer, at most sixteen commands.
// - Keep bit clear releases selects after transfer; set holds them asserted.
// - Width bit clear gives eight bits, set uses bits-per-transfer field.
// - Post delay bit selects programmable delay after each transfer.
// - Post delay is 32 times field, 8192 when zero, else standard 17.
// - Clock delay bit clear gives half serial period before first edge.
// - Clock delay bit set gives field value, 1 to 127, system clocks.
// - Several chip selects may be asserted together for one command.
// - Slave select pulled low while master sets the mode fault flag.
// - Master select bit chooses master or slave operation.
// - Master runs the queue, drives selects, sends and stores words.
// - Slave drives its data pin only when selected, drives no selects, other width rule.
// - Each frame of bits-per-transfer link clocks performs the next queue transfer, selected or not.
// - Mode fault leaves master select and drivers alone; only enable disables.
// - Finished flag set after executing the end-pointer command.
`timescale 1ns/1ps

module qscq_core #(
    parameter int POST_ZERO_CYCLES = qscq_pkg::POST_ZERO_CLOCKS
) (
    // System clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Configuration and control
    input wire qscq_pkg::qscq_cfg_type cfg,
    input wire logic queue_start,
    input wire logic finished_clear,
    input wire logic mode_fault_clear,
    // Host memory ports
    input wire logic cmd_we,
    input wire logic [qscq_pkg::PTR_W-1:0] cmd_addr,
    input wire logic [qscq_pkg::CMD_W-1:0] cmd_data,
    input wire logic tx_we,
    input wire logic [qscq_pkg::PTR_W-1:0] tx_addr,
    input wire logic [qscq_pkg::WORD_W-1:0] tx_data,
    input wire logic [qscq_pkg::PTR_W-1:0] rx_addr,
    output logic [qscq_pkg::WORD_W-1:0] rx_data,
    // Status
    output qscq_pkg::qscq_status_type status,
    // Serial clock pin, link clock in slave operation
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    // Master-out data pin
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    // Master-in data pin
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n,
    // Peripheral selects; bit 0 pin doubles as slave select input
    input wire logic slave_select_n,
    output logic [3:0] sel_out,
    output logic [3:0] sel_oe_n
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        qscq_pkg::qscq_state_type state;
        logic running;
        logic [qscq_pkg::PTR_W-1:0] ptr;
        qscq_pkg::qscq_cmd_type cmd;
        logic [qscq_pkg::CNT_W-1:0] bits;
        logic [qscq_pkg::CNT_W-1:0] cnt;
        logic [qscq_pkg::TMR_W-1:0] timer;
        logic [qscq_pkg::WORD_W-1:0] tx_sh;
        logic [qscq_pkg::WORD_W-1:0] rx_sh;
        logic [qscq_pkg::WORD_W-1:0] slave_tx;
        logic sck;
        logic mosi;
        logic [3:0] sel;
        logic [3:0] sel_oe_n;
        logic drive_n;
        logic miso_oe_n;
        logic finished;
        logic fault;
        logic [qscq_pkg::PTR_W-1:0] cptr;
        logic [qscq_pkg::WORD_W-1:0] rx_data;
        logic [1:0] ss_sync;
        logic [1:0] miso_sync;
        logic [2:0] done_sync;
        logic [qscq_pkg::ENTRIES-1:0][qscq_pkg::CMD_W-1:0] cmd_mem;
        logic [qscq_pkg::ENTRIES-1:0][qscq_pkg::WORD_W-1:0] tx_mem;
        logic [qscq_pkg::ENTRIES-1:0][qscq_pkg::WORD_W-1:0] rx_mem;
    } qscq_core_type;

    typedef struct packed {
        logic [qscq_pkg::CNT_W-1:0] cnt;
        logic [qscq_pkg::WORD_W-1:0] rx_sh;
        logic miso;
        logic done_tgl;
    } qscq_link_type;

    qscq_core_type s_q;
    qscq_core_type s_d;
    qscq_link_type l_q;
    qscq_link_type l_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Bits per transfer field: zero means sixteen
    function automatic logic [qscq_pkg::CNT_W-1:0] field_bits(input logic [3:0] f);
        field_bits = (f == 4'h0) ? qscq_pkg::FULL_BITS : {1'b0, f};
    endfunction

    function automatic logic [qscq_pkg::WORD_W-1:0] low_mask(
        input logic [qscq_pkg::CNT_W-1:0] n);
        low_mask = (n >= qscq_pkg::FULL_BITS) ? 16'hffff :
            ((16'h0001 << n[3:0]) - 16'h0001);
    endfunction

    function automatic logic [qscq_pkg::TMR_W-1:0] post_clocks(
        input qscq_pkg::qscq_cmd_type c, input logic [7:0] len);
        if (!c.post_delay_select) begin
            post_clocks = qscq_pkg::STD_POST_CLOCKS;
        end else if (len == 8'h00) begin
            post_clocks = qscq_pkg::TMR_W'(POST_ZERO_CYCLES);
        end else begin
            post_clocks = qscq_pkg::TMR_W'({len, 5'h00});
        end
    endfunction

    function automatic logic [qscq_pkg::TMR_W-1:0] half_clocks(input logic [7:0] h);
        half_clocks = (h == 8'h00) ? 14'h0001 : {6'h00, h};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: slave frames clocked by the external master
    always_comb begin
        l_d = l_q;
        l_d.rx_sh = {l_q.rx_sh[qscq_pkg::WORD_W-2:0], mosi_in};
        // Transmit word held steady by the system side for the whole frame
        l_d.miso = s_q.slave_tx[4'(field_bits(cfg.bits_per_transfer) - 5'h01 - l_q.cnt)];
        if (l_q.cnt + 5'h01 >= field_bits(cfg.bits_per_transfer)) begin
            l_d.cnt = '0;
            l_d.done_tgl = ~l_q.done_tgl;
        end else begin
            l_d.cnt = l_q.cnt + 5'h01;
        end
    end

    // Aborted frames leave a partial count; reset the port to recover
    always_ff @(posedge sck_in or negedge rst_n) begin
        if (!rst_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // System domain
    always_comb begin
        logic tick;
        logic last;
        logic slave_done;
        logic fault_set;
        qscq_pkg::qscq_cmd_type c;
        tick = 1'b0;
        last = 1'b0;
        slave_done = 1'b0;
        fault_set = 1'b0;
        c = '0;
        s_d = s_q;
        s_d.ss_sync = {s_q.ss_sync[0], slave_select_n};
        s_d.miso_sync = {s_q.miso_sync[0], miso_in};
        s_d.done_sync = {s_q.done_sync[1:0], l_q.done_tgl};
        slave_done = s_q.done_sync[2] ^ s_q.done_sync[1];
        if (cmd_we) begin
            s_d.cmd_mem[cmd_addr] = cmd_data;
        end
        if (tx_we) begin
            s_d.tx_mem[tx_addr] = tx_data;
        end
        s_d.rx_data = s_q.rx_mem[rx_addr];
        tick = (s_q.timer <= 14'h0001);
        s_d.timer = tick ? s_q.timer : s_q.timer - 14'h0001;
        last = (s_q.ptr == cfg.queue_end_pointer);
        // Fault only while enabled master; set wins over clear
        fault_set = cfg.serial_enable && cfg.master_select && !s_q.ss_sync[1];
        s_d.fault = (s_q.fault && !mode_fault_clear) || fault_set;
        s_d.finished = s_q.finished && !finished_clear;
        // Drivers follow enable, master select and slave select, never the fault flag
        s_d.drive_n = !(cfg.serial_enable && cfg.master_select);
        s_d.miso_oe_n = !(cfg.serial_enable && !cfg.master_select &&
            !s_q.ss_sync[1]);
        case (s_q.state)
            qscq_pkg::ST_IDLE: begin
                if (queue_start && cfg.serial_enable) begin
                    s_d.running = 1'b1;
                    s_d.ptr = cfg.queue_start_pointer;
                    // A count left by an earlier queue would skip the first entry
                    s_d.cnt = '0;
                    if (cfg.master_select) begin
                        s_d.state = qscq_pkg::ST_POST;
                        s_d.timer = 14'h0001;
                    end else begin
                        s_d.state = qscq_pkg::ST_SLAVE;
                        s_d.slave_tx = s_q.tx_mem[cfg.queue_start_pointer];
                    end
                end
            end
            qscq_pkg::ST_LEAD: begin
                // First rising edge ends the lead, so lead equals the programmed delay
                if (tick) begin
                    s_d.state = qscq_pkg::ST_SHIFT;
                    s_d.timer = half_clocks(cfg.sck_half_period);
                    s_d.sck = 1'b1;
                    s_d.rx_sh = {s_q.rx_sh[qscq_pkg::WORD_W-2:0], s_q.miso_sync[1]};
                    s_d.cnt = s_q.cnt + 5'h01;
                end
            end
            qscq_pkg::ST_SHIFT: begin
                if (tick) begin
                    s_d.timer = half_clocks(cfg.sck_half_period);
                    if (!s_q.sck) begin
                        s_d.sck = 1'b1;
                        s_d.rx_sh = {s_q.rx_sh[qscq_pkg::WORD_W-2:0], s_q.miso_sync[1]};
                        s_d.cnt = s_q.cnt + 5'h01;
                    end else begin
                        s_d.sck = 1'b0;
                        if (s_q.cnt == s_q.bits) begin
                            // Right-justified, upper bits cleared by the zero start
                            s_d.rx_mem[s_q.ptr] = s_q.rx_sh;
                            // Released for the whole post delay: a deselect interval
                            if (!s_q.cmd.keep_select_bit) begin
                                s_d.sel_oe_n = qscq_pkg::SEL_RELEASED;
                            end
                            s_d.state = qscq_pkg::ST_POST;
                            s_d.timer = post_clocks(s_q.cmd, cfg.post_delay_length);
                        end else begin
                            s_d.tx_sh = s_q.tx_sh << 1;
                            s_d.mosi = s_q.tx_sh[qscq_pkg::WORD_W-2];
                        end
                    end
                end
            end
            qscq_pkg::ST_POST: begin
                if (tick) begin
                    if (s_q.running && s_q.cnt != '0) begin
                        s_d.cptr = s_q.ptr;
                    end
                    if (s_q.cnt != '0 && last) begin
                        s_d.finished = 1'b1;
                        s_d.running = 1'b0;
                        s_d.state = qscq_pkg::ST_IDLE;
                    end else begin
                        // Next entry: first entry arrives here with a zero count
                        c = qscq_pkg::qscq_cmd_type'(s_q.cmd_mem[s_d.ptr]);
                        if (s_q.cnt != '0) begin
                            s_d.ptr = s_q.ptr + 4'h1;
                            c = qscq_pkg::qscq_cmd_type'(s_q.cmd_mem[s_q.ptr + 4'h1]);
                        end
                        s_d.cmd = c;
                        s_d.bits = c.width_select_bit ?
                            field_bits(cfg.bits_per_transfer) : qscq_pkg::DEFAULT_BITS;
                        s_d.sel = c.peripheral_select;
                        s_d.sel_oe_n = 4'h0;
                        s_d.tx_sh = s_q.tx_mem[s_d.ptr] << (5'h10 - s_d.bits);
                        s_d.mosi = s_d.tx_sh[qscq_pkg::WORD_W-1];
                        s_d.rx_sh = qscq_pkg::WORD_RESET;
                        s_d.cnt = '0;
                        s_d.sck = 1'b0;
                        s_d.state = qscq_pkg::ST_LEAD;
                        s_d.timer = c.clock_delay_select ?
                            {7'h00, cfg.clock_delay_length} :
                            half_clocks(cfg.sck_half_period);
                    end
                end
            end
            qscq_pkg::ST_SLAVE: begin
                // No selects are driven; command select field unused
                s_d.sel_oe_n = qscq_pkg::SEL_RELEASED;
                if (slave_done) begin
                    s_d.rx_mem[s_q.ptr] = l_q.rx_sh &
                        low_mask(field_bits(cfg.bits_per_transfer));
                    s_d.cptr = s_q.ptr;
                    if (last) begin
                        s_d.finished = 1'b1;
                        s_d.running = 1'b0;
                        s_d.state = qscq_pkg::ST_IDLE;
                    end else begin
                        s_d.ptr = s_q.ptr + 4'h1;
                        s_d.slave_tx = s_q.tx_mem[s_q.ptr + 4'h1];
                    end
                end
            end
            default: begin
                s_d.state = qscq_pkg::ST_IDLE;
            end
        endcase
        // Disable stops the queue and releases every pin
        if (!cfg.serial_enable) begin
            s_d.state = qscq_pkg::ST_IDLE;
            s_d.running = 1'b0;
            s_d.sck = 1'b0;
            s_d.sel_oe_n = qscq_pkg::SEL_RELEASED;
        end
        // Slave operation never owns the select pins, even while idle
        if (!cfg.master_select) begin
            s_d.sel_oe_n = qscq_pkg::SEL_RELEASED;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.state <= qscq_pkg::ST_IDLE;
            s_q.ptr <= qscq_pkg::PTR_RESET;
            s_q.cptr <= qscq_pkg::PTR_RESET;
            s_q.sel_oe_n <= qscq_pkg::SEL_RELEASED;
            s_q.drive_n <= 1'b1;
            s_q.miso_oe_n <= 1'b1;
            s_q.ss_sync <= 2'h3;
            s_q.timer <= 14'h0001;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign rx_data = s_q.rx_data;
    assign status = '{finished_flag: s_q.finished, mode_fault_flag: s_q.fault,
        busy: s_q.running, completed_pointer: s_q.cptr};
    assign sck_out = s_q.sck;
    assign sck_oe_n = s_q.drive_n;
    assign mosi_out = s_q.mosi;
    assign mosi_oe_n = s_q.drive_n;
    assign miso_out = l_q.miso;
    assign miso_oe_n = s_q.miso_oe_n;
    assign sel_out = s_q.sel;
    assign sel_oe_n = s_q.sel_oe_n;
endmodule

// >>> dv/qscq_core_props.sv
// Purpose: Port assertions for the command queue core
// Assumes: All watched ports belong to the system clock domain
// Notes: Bound to every core instance
`timescale 1ns/1ps
module qscq_core_props #(
    parameter int POST_ZERO_CYCLES = 8192
) (
    // Clock, reset and control
    input wire logic clock,
    input wire logic rst_n,
    input wire qscq_pkg::qscq_cfg_type cfg,
    input wire logic queue_start,
    input wire logic finished_clear,
    input wire logic mode_fault_clear,
    input wire logic slave_select_n,
    // Watched outputs
    input wire qscq_pkg::qscq_status_type status,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic miso_oe_n,
    input wire logic [3:0] sel_oe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic en_m;
    assign en_m = cfg.serial_enable && cfg.master_select;
    //////////////////////////////
    a_start_sets_busy: assert property (queue_start && cfg.serial_enable && !status.busy
        |=> status.busy) else $error("start did not raise busy");
    a_off_stops_busy: assert property (!cfg.serial_enable |=> !status.busy)
        else $error("busy kept while disabled");
    a_off_releases_pins: assert property (!cfg.serial_enable && $past(!cfg.serial_enable)
        |-> sel_oe_n == 4'hf && sck_oe_n && miso_oe_n) else $error("pins driven while off");
    a_fault_sets_flag: assert property ((en_m && !slave_select_n && !mode_fault_clear)[*4]
        |=> status.mode_fault_flag) else $error("mode fault not flagged");
    a_fault_keeps_drive: assert property (en_m && $past(en_m) && status.mode_fault_flag
        |-> !sck_oe_n) else $error("fault released clock driver");
    a_slave_no_selects: assert property (!cfg.master_select && $past(!cfg.master_select)
        |-> sel_oe_n == 4'hf) else $error("selects driven in slave operation");
    a_idle_clock_low: assert property (!status.busy |-> !sck_out)
        else $error("serial clock high while idle");
    a_finish_ends_run: assert property ($rose(status.finished_flag) |-> ##[0:2] !status.busy)
        else $error("still busy after finishing");
    a_finish_clears: assert property (status.finished_flag && finished_clear && !status.busy
        |=> !status.finished_flag) else $error("finished flag not cleared");
    // Main scenarios reached
    c_finished: cover property ($rose(status.finished_flag));
    c_fault: cover property ($rose(status.mode_fault_flag));
    c_slave_frame: cover property (!miso_oe_n);
endmodule

bind qscq_core qscq_core_props #(.POST_ZERO_CYCLES(POST_ZERO_CYCLES)) i_props (
    .clock(clock), .rst_n(rst_n), .cfg(cfg), .queue_start(queue_start),
    .finished_clear(finished_clear), .mode_fault_clear(mode_fault_clear),
    .slave_select_n(slave_select_n), .status(status), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .miso_oe_n(miso_oe_n), .sel_oe_n(sel_oe_n));

// >>> dv/qscq_peri_model.sv
// Purpose: Far-side peripheral answering master transfers
// Assumes: Peripheral echoes inverted data while any select is driven
// Notes: Released line toggles so a stale value never passes
`timescale 1ns/1ps
module qscq_peri_model (
    // Clock and answer speed
    input wire logic clock,
    input wire logic slow,
    // Pins seen from the far side
    input wire logic mosi_pin,
    input wire logic [3:0] sel_oe_n,
    output logic miso_drive
);
    logic filler = 1'b0;
    logic echo_slow;
    always @(posedge clock) filler <= ~filler;
    // Slow answer still lands well before the sampling edge
    assign #12 echo_slow = ~mosi_pin;
    assign miso_drive = (sel_oe_n != 4'hf) ? (slow ? echo_slow : ~mosi_pin) : filler;
endmodule

// >>> dv/qscq_core_test.sv
// Purpose: Self-checking bench for the command queue core
// Assumes: Zero-length post delay shortened to 64 clocks
// Notes: Link clock is the core's own serial clock in master tests, external only in slave frames
`timescale 1ns/1ps
module qscq_core_test;
    logic clock, rst_n, queue_start, finished_clear, mode_fault_clear;
    qscq_pkg::qscq_cfg_type cfg;
    qscq_pkg::qscq_status_type status;
    logic cmd_we, tx_we, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
    logic [3:0] cmd_addr, tx_addr, rx_addr, sel_out, sel_oe_n, seen[2];
    logic [7:0] cmd_data;
    logic [15:0] tx_data, rx_data, shifted[2];
    logic ext_sck, ext_mosi, ext_ss_n, peri_miso, slow, sck_w, mosi_w, miso_w, ss_w;
    int fails = 0;
    int check_count = 0;
    int lead[2], post[2], edges[2], gap[2];
    // Pin levels from every party's enable
    assign sck_w = sck_oe_n ? ext_sck : sck_out;
    assign mosi_w = mosi_oe_n ? ext_mosi : mosi_out;
    assign miso_w = miso_oe_n ? peri_miso : miso_out;
    assign ss_w = sel_oe_n[0] ? ext_ss_n : sel_out[0];
    qscq_core #(.POST_ZERO_CYCLES(64)) i_dut (.clock(clock), .rst_n(rst_n), .cfg(cfg),
        .queue_start(queue_start), .finished_clear(finished_clear),
        .mode_fault_clear(mode_fault_clear), .cmd_we(cmd_we), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .tx_we(tx_we), .tx_addr(tx_addr), .tx_data(tx_data),
        .rx_addr(rx_addr), .rx_data(rx_data), .status(status), .sck_in(sck_w),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
        .slave_select_n(ss_w), .sel_out(sel_out), .sel_oe_n(sel_oe_n));
    qscq_peri_model i_peri (.clock(clock), .slow(slow), .mosi_pin(mosi_w),
        .sel_oe_n(sel_oe_n), .miso_drive(peri_miso));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    //////////////////////////////
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic put_cmd(input logic [3:0] a, input logic [7:0] c, input logic [15:0] w);
        cmd_we = 1'b1;
        tx_we = 1'b1;
        cmd_addr = a;
        tx_addr = a;
        cmd_data = c;
        tx_data = w;
        tick(1);
        cmd_we = 1'b0;
        tx_we = 1'b0;
    endtask
    task automatic read_rx(input logic [3:0] a, input logic [15:0] exp);
        rx_addr = a;
        tick(2);
        cmp(rx_data, exp);
    endtask
    // Runs a two-entry queue, timing each entry in system clocks
    task automatic run_queue(input logic [3:0] s);
        int k = 0;
        int sel_t = 0;
        int fall_t = 0;
        logic first = 1'b0;
        logic ps = 1'b0;
        logic [3:0] po = sel_oe_n;
        logic [3:0] pd = sel_out;
        logic [3:0] pc = status.completed_pointer;
        cfg.queue_start_pointer = s;
        cfg.queue_end_pointer = s + 4'h1;
        edges = '{0, 0};
        gap = '{0, 0};
        shifted = '{16'h0000, 16'h0000};
        queue_start = 1'b1;
        tick(1);
        queue_start = 1'b0;
        for (int t = 0; t < 8000 && k < 2; t++) begin
            tick(1);
            if (sel_oe_n !== po || sel_out !== pd) begin
                sel_t = t;
                first = 1'b1;
            end
            if (sck_out && !ps) begin
                if (first) lead[k] = t - sel_t;
                if (first) seen[k] = sel_out;
                first = 1'b0;
                edges[k]++;
                shifted[k] = {shifted[k][14:0], mosi_out};
            end
            if (!sck_out && ps) fall_t = t;
            if (status.completed_pointer !== pc) begin
                post[k] = t - fall_t;
                k++;
            end
            if (k < 2 && sel_oe_n === 4'hf && status.busy) gap[k] = 1;
            ps = sck_out;
            po = sel_oe_n;
            pd = sel_out;
            pc = status.completed_pointer;
        end
        if (k < 2) begin
            fails++;
            tally_and_finish();
        end
        tick(4);
    endtask
    //////////////////////////////
    task automatic t_master_timing;
        put_cmd(4'h2, 8'h93, 16'ha5c3);
        put_cmd(4'h3, 8'h65, 16'h3e71);
        run_queue(4'h2);
        cmp(16'(edges[0]), 16'h0008);
        cmp(16'(edges[1]), 16'h000c);
        cmp(shifted[0], 16'h00c3);
        cmp(shifted[1], 16'h0e71);
        cmp(16'(lead[0] - lead[1]), 16'h0005);
        cmp(16'(lead[1]), 16'h0004);
        cmp(16'(post[1] - post[0]), 16'h000f);
        cmp(16'(post[0]), 16'h0011);
        cmp(16'(gap[0]), 16'h0000);
        cmp(16'(gap[1]), 16'h0001);
        cmp({seen[0], seen[1]}, 16'h0035);
        cmp(sel_oe_n, 4'hf);
        cmp({status.finished_flag, status.completed_pointer}, 16'h0013);
        read_rx(4'h2, 16'h003c);
        read_rx(4'h3, 16'h018e);
        finished_clear = 1'b1;
        tick(1);
        finished_clear = 1'b0;
        tick(1);
        cmp(status.finished_flag, 1'b0);
    endtask
    task automatic t_master_long;
        cfg.bits_per_transfer = 4'h0;
        cfg.post_delay_length = 8'h00;
        slow = 1'b1;
        put_cmd(4'h5, 8'h61, 16'hbeef);
        put_cmd(4'h6, 8'h03, 16'h1234);
        run_queue(4'h5);
        cmp(shifted[0], 16'hbeef);
        cmp(16'(post[0] - post[1]), 16'h002f);
        cmp(16'(gap[0]), 16'h0001);
        cmp(16'(gap[1]), 16'h0001);
        cmp(16'(lead[0] - lead[1]), 16'h0000);
        read_rx(4'h5, 16'h4110);
        read_rx(4'h6, 16'h00cb);
        cmp({status.finished_flag, status.completed_pointer}, 16'h0016);
    endtask
    task automatic t_mode_fault;
        ext_ss_n = 1'b0;
        tick(6);
        cmp({status.mode_fault_flag, sck_oe_n}, 16'h0002);
        ext_ss_n = 1'b1;
        tick(3);
        mode_fault_clear = 1'b1;
        tick(1);
        mode_fault_clear = 1'b0;
        tick(1);
        cmp(status.mode_fault_flag, 1'b0);
        cfg.serial_enable = 1'b0;
        tick(2);
        cmp({sck_oe_n, sel_oe_n}, 16'h001f);
    endtask
    task automatic t_slave;
        logic [15:0] got = 16'h0000;
        cfg.master_select = 1'b0;
        cfg.bits_per_transfer = 4'ha;
        cfg.serial_enable = 1'b1;
        put_cmd(4'h8, 8'h0e, 16'h02b5);
        run_start(4'h8);
        ext_ss_n = 1'b0;
        tick(4);
        #7;
        for (int i = 9; i >= 0; i--) begin
            ext_mosi = 1'(10'h1c3 >> i);
            #16 ext_sck = 1'b1;
            #16 got = {got[14:0], miso_w};
            ext_sck = 1'b0;
        end
        cmp({miso_oe_n, sel_oe_n}, 16'h000f);
        ext_mosi = ~ext_mosi;
        #20 ext_ss_n = 1'b1;
        tick(20);
        cmp(got, 16'h02b5);
        cmp({status.finished_flag, status.completed_pointer}, 16'h0018);
        read_rx(4'h8, 16'h01c3);
    endtask
    task automatic run_start(input logic [3:0] s);
        cfg.queue_start_pointer = s;
        cfg.queue_end_pointer = s;
        queue_start = 1'b1;
        finished_clear = 1'b1;
        tick(1);
        queue_start = 1'b0;
        finished_clear = 1'b0;
    endtask
    //////////////////////////////
    initial begin
        {rst_n, queue_start, finished_clear, mode_fault_clear, cmd_we, tx_we} = 6'h00;
        {cmd_addr, tx_addr, rx_addr, cmd_data, tx_data} = 36'h0;
        {ext_sck, ext_mosi, ext_ss_n, slow} = 4'h2;
        cfg = '{1'b1, 1'b1, 4'hc, 8'h04, 7'h09, 8'h01, 4'h0, 4'h0};
        tick(12);
        rst_n = 1'b1;
        tick(2);
        cmp(16'({status, sel_oe_n}), 16'h000f);
        t_master_timing();
        t_master_long();
        t_mode_fault();
        t_slave();
        tally_and_finish();
    end
endmodule
